//--- verilog/scfrz_top.sv
// freeze controller, fabric interface disables, ecc/parity control, pin mux and message registers
`timescale 1ns/10ps
`include "scfrz_consts.svh"

module scfrz_top
   import scfrz_pkg::*;
#(
   parameter int N_ECC = 11,
   parameter int N_PIN = 16,
   parameter int N_STRAP = 3,
   parameter int N_MSG = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cold_presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SCFRZ_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output scfrz_gate_type [3:0] frz_gate,
   output logic [6:0] fabric_intf_dis,
   output scfrz_ecc_type [N_ECC-1:0] ecc_ctrl,
   input wire logic [N_ECC-1:1] ecc_sgl_err,
   input wire logic [N_ECC-1:1] ecc_dbl_err,
   output logic [N_ECC-1:1] ecc_sgl_irq,
   output logic [N_ECC-1:1] ecc_dbl_irq,
   output logic [7:0] parity_inj,
   output logic [2*N_PIN-1:0] pin_sel,
   input wire logic [N_STRAP-1:0] boot_strap
);

   //****************************************************************
   // parameter checks
   //****************************************************************
   if (N_ECC != 11 || N_MSG != 8 || N_PIN > 16 || N_PIN < 1 || N_STRAP > 32 || N_STRAP < 1) begin : g_chk
      $error("scfrz_top: unsupported parameter values");
   end

   localparam logic [3:0] STEP_CYC = 4'(`SCFRZ_STEP_CYC);
   localparam logic [3:0] LAST_STEP = 4'(`SCFRZ_GATE_W - 1);

   //****************************************************************
   // apb slave
   //****************************************************************
   function automatic logic in_block(input logic [`SCFRZ_ADDR_W-1:0] a, input logic [`SCFRZ_ADDR_W-1:0] base,
                                     input int n);
      in_block = (a >= base) && (a < base + `SCFRZ_ADDR_W'(4 * n)) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [1:0] state_code(input scfrz_hw_state_type s);
      case (s)
         S_FROZEN: state_code = `SCFRZ_CODE_FROZEN;
         S_THAWING: state_code = `SCFRZ_CODE_THAWING;
         S_THAWED: state_code = `SCFRZ_CODE_THAWED;
         default: state_code = `SCFRZ_CODE_FREEZING;
      endcase
   endfunction

   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic hit;
   logic rd_cap;
   logic wr_en;
   logic [`SCFRZ_ADDR_W-3:0] widx;

   scfrz_gate_type [3:0] chan_reg;
   logic src_reg;
   logic gbl_reg;
   logic [6:0] indiv_reg;
   scfrz_ecc_type [N_ECC-1:0] ecc_reg;
   logic [7:0] parity_reg;
   logic [31:0] pinmux_reg;
   logic [31:0] msg_reg [N_MSG];
   logic [N_STRAP-1:0] strap_reg;
   scfrz_hw_state_type hw_state_reg;
   scfrz_gate_type hw_gate_reg;
   logic [3:0] hw_step_reg;
   logic [3:0] hw_tmr_reg;
   logic hw_req;
   logic hw_start;

   assign rd_cap = psel & penable & ~pready_reg;
   assign wr_en = psel & penable & pwrite & pready_reg;
   assign widx = paddr[`SCFRZ_ADDR_W-1:2];

   always_comb begin
      hit = 1'b1;
      prdata_next = 32'h0000_0000;
      if (in_block(paddr, `SCFRZ_OFF_CHAN_BASE, 4)) begin
         prdata_next[`SCFRZ_GATE_W-1:0] = chan_reg[paddr[3:2]];
      end else if (paddr == `SCFRZ_OFF_SRC) begin
         prdata_next[0] = src_reg;
      end else if (paddr == `SCFRZ_OFF_HWCTRL) begin
         prdata_next[`SCFRZ_HW_STATE_LSB +: 2] = state_code(hw_state_reg);
      end else if (paddr == `SCFRZ_OFF_INTF_GBL) begin
         prdata_next[0] = gbl_reg;
      end else if (paddr == `SCFRZ_OFF_INTF_INDIV) begin
         prdata_next[6:0] = indiv_reg;
      end else if (in_block(paddr, `SCFRZ_OFF_ECC_BASE, N_ECC)) begin
         prdata_next[2:0] = ecc_reg[4'(widx - `SCFRZ_OFF_ECC_BASE / 4)];
      end else if (paddr == `SCFRZ_OFF_PARITY) begin
         prdata_next[7:0] = parity_reg;
      end else if (paddr == `SCFRZ_OFF_PINMUX) begin
         prdata_next = pinmux_reg;
      end else if (paddr == `SCFRZ_OFF_STRAP) begin
         prdata_next[N_STRAP-1:0] = strap_reg;
      end else if (in_block(paddr, `SCFRZ_OFF_MSG_BASE, N_MSG)) begin
         prdata_next = msg_reg[3'(widx - `SCFRZ_OFF_MSG_BASE / 4)];
      end else begin
         hit = 1'b0;
      end
   end

   // one wait state: data and ready rise one edge into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= rd_cap;
         pslverr_reg <= rd_cap & ~hit;
         if (rd_cap && !pwrite) begin
            prdata_reg <= prdata_next;
         end
      end
   end

   //****************************************************************
   // cold-reset-only registers
   //****************************************************************
   always_ff @(posedge pclk or negedge cold_presetn) begin
      if (!cold_presetn) begin
         chan_reg <= {4{`SCFRZ_RST_CHAN}};
         src_reg <= `SCFRZ_RST_SRC;
         gbl_reg <= `SCFRZ_RST_INTF_GBL;
         indiv_reg <= `SCFRZ_RST_INTF_INDIV;
         ecc_reg <= {N_ECC{`SCFRZ_RST_ECC}};
         pinmux_reg <= `SCFRZ_RST_PINMUX;
      end else if (wr_en && hit) begin
         if (in_block(paddr, `SCFRZ_OFF_CHAN_BASE, 4)) begin
            chan_reg[paddr[3:2]] <= pwdata[`SCFRZ_GATE_W-1:0];
         end
         if (paddr == `SCFRZ_OFF_SRC) begin
            src_reg <= pwdata[0];
         end
         if (paddr == `SCFRZ_OFF_INTF_GBL) begin
            gbl_reg <= pwdata[0];
         end
         if (paddr == `SCFRZ_OFF_INTF_INDIV) begin
            indiv_reg <= pwdata[6:0];
         end
         if (in_block(paddr, `SCFRZ_OFF_ECC_BASE, N_ECC)) begin
            ecc_reg[4'(widx - `SCFRZ_OFF_ECC_BASE / 4)] <= pwdata[2:0];
         end
         if (paddr == `SCFRZ_OFF_PINMUX) begin
            pinmux_reg <= pwdata;
         end
      end
   end

   // message words: plain storage, cleared by cold reset only
   always_ff @(posedge pclk or negedge cold_presetn) begin
      if (!cold_presetn) begin
         for (int i = 0; i < N_MSG; i++) begin
            msg_reg[i] <= `SCFRZ_RST_MSG;
         end
      end else if (wr_en && in_block(paddr, `SCFRZ_OFF_MSG_BASE, N_MSG)) begin
         msg_reg[3'(widx - `SCFRZ_OFF_MSG_BASE / 4)] <= pwdata;
      end
   end

   // parity injection clears on warm reset only, not on cold reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parity_reg <= `SCFRZ_RST_PARITY;
      end else if (wr_en && paddr == `SCFRZ_OFF_PARITY) begin
         parity_reg <= pwdata[7:0];
      end
   end

   //****************************************************************
   // boot strap capture at cold release
   //****************************************************************
   logic [N_STRAP-1:0] strap_s1_reg;
   logic [N_STRAP-1:0] strap_s2_reg;
   logic [1:0] strap_cnt_reg;

   always_ff @(posedge pclk or negedge cold_presetn) begin
      if (!cold_presetn) begin
         strap_s1_reg <= '0;
         strap_s2_reg <= '0;
         strap_reg <= '0;
         strap_cnt_reg <= 2'h0;
      end else begin
         strap_s1_reg <= boot_strap;
         strap_s2_reg <= strap_s1_reg;
         // third edge after release: the second stage now holds the pin level
         if (strap_cnt_reg == 2'h2) begin
            strap_reg <= strap_s2_reg;
         end
         if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
         end
      end
   end

   //****************************************************************
   // hardware freeze sequencer, vertical channel 1
   //****************************************************************
   assign hw_req = wr_en && paddr == `SCFRZ_OFF_HWCTRL && pwdata[`SCFRZ_HW_REQ_BIT];
   assign hw_start = hw_req && (hw_state_reg == S_FROZEN || hw_state_reg == S_THAWED);

   always_ff @(posedge pclk or negedge cold_presetn) begin
      if (!cold_presetn) begin
         hw_state_reg <= S_FROZEN;
         hw_gate_reg <= `SCFRZ_RST_CHAN;
         hw_step_reg <= 4'h0;
         hw_tmr_reg <= 4'h0;
      end else begin
         case (hw_state_reg)
            S_FROZEN, S_THAWED: begin
               hw_step_reg <= 4'h0;
               hw_tmr_reg <= STEP_CYC;
               if (hw_start) begin
                  hw_state_reg <= (hw_state_reg == S_FROZEN) ? S_THAWING : S_FREEZING;
               end
            end
            S_THAWING, S_FREEZING: begin
               if (hw_tmr_reg == 4'h1) begin
                  // thaw releases fields last-to-first, freeze drops them first-to-last
                  if (hw_state_reg == S_THAWING) begin
                     hw_gate_reg[LAST_STEP - hw_step_reg] <= 1'b1;
                  end else begin
                     hw_gate_reg[hw_step_reg] <= 1'b0;
                  end
                  hw_tmr_reg <= STEP_CYC;
                  hw_step_reg <= hw_step_reg + 4'h1;
                  if (hw_step_reg == LAST_STEP) begin
                     hw_state_reg <= (hw_state_reg == S_THAWING) ? S_THAWED : S_FROZEN;
                  end
               end else begin
                  hw_tmr_reg <= hw_tmr_reg - 4'h1;
               end
            end
            default: hw_state_reg <= S_FROZEN;
         endcase
      end
   end

   //****************************************************************
   // output registers
   //****************************************************************
   // configuration registers in the io are never reset here; a zero gate blocks them instead
   always_ff @(posedge pclk or negedge cold_presetn) begin
      if (!cold_presetn) begin
         frz_gate <= {4{`SCFRZ_RST_CHAN}};
         fabric_intf_dis <= '0;
         ecc_ctrl <= {N_ECC{`SCFRZ_RST_ECC}};
         pin_sel <= '0;
      end else begin
         for (int c = 0; c < 4; c++) begin
            frz_gate[c] <= chan_reg[c];
         end
         if (src_reg) begin
            frz_gate[1] <= hw_gate_reg;
         end
         fabric_intf_dis <= indiv_reg | {7{gbl_reg}};
         ecc_ctrl <= ecc_reg;
         pin_sel <= pinmux_reg[2*N_PIN-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ecc_sgl_irq <= '0;
         ecc_dbl_irq <= '0;
         parity_inj <= `SCFRZ_RST_PARITY;
      end else begin
         ecc_sgl_irq <= ecc_sgl_err;
         ecc_dbl_irq <= ecc_dbl_err;
         parity_inj <= parity_reg;
      end
   end

   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;

   //****************************************************************
   // assertions
   //****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !cold_presetn);

   property p_frozen_gated;
      (src_reg && hw_state_reg == S_FROZEN) |=> frz_gate[1] == `SCFRZ_RST_CHAN;
   endproperty
   a_frozen_gated: assert property (p_frozen_gated) else $error("frozen channel 1 not gated");

   property p_chan_indep;
      (wr_en && paddr == `SCFRZ_OFF_CHAN_BASE + 12'h008) |=> $stable(chan_reg[0]) && $stable(chan_reg[3]);
   endproperty
   a_chan_indep: assert property (p_chan_indep) else $error("channel write disturbed another channel");

   property p_sw_source;
      (!src_reg && wr_en && paddr == `SCFRZ_OFF_CHAN_BASE + 12'h004) |=> ##1
         frz_gate[1] == $past(pwdata[`SCFRZ_GATE_W-1:0], 2);
   endproperty
   a_sw_source: assert property (p_sw_source) else $error("software freeze field not on channel 1");

   property p_hw_start;
      hw_start |=> hw_state_reg == S_THAWING || hw_state_reg == S_FREEZING;
   endproperty
   a_hw_start: assert property (p_hw_start) else $error("request did not start sequencer");

   property p_hw_busy;
      (hw_state_reg == S_THAWING) |=> hw_state_reg == S_THAWING || hw_state_reg == S_THAWED;
   endproperty
   a_hw_busy: assert property (p_hw_busy) else $error("thaw sequence diverted");

   property p_hw_settle;
      $rose(hw_state_reg == S_THAWED) |-> hw_gate_reg == {`SCFRZ_GATE_W{1'b1}} && $past(hw_state_reg == S_THAWING);
   endproperty
   a_hw_settle: assert property (p_hw_settle) else $error("thawed without full release");

   property p_state_read;
      (rd_cap && !pwrite && paddr == `SCFRZ_OFF_HWCTRL) |=>
         pready && prdata[`SCFRZ_HW_STATE_LSB +: 2] == state_code($past(hw_state_reg));
   endproperty
   a_state_read: assert property (p_state_read) else $error("state field mismatch");

   property p_gbl;
      gbl_reg |=> fabric_intf_dis == 7'h7F;
   endproperty
   a_gbl: assert property (p_gbl) else $error("global disable not applied");

   property p_ecc_irq;
      ecc_dbl_err[1] |=> ecc_dbl_irq[1];
   endproperty
   a_ecc_irq: assert property (p_ecc_irq) else $error("ecc interrupt not forwarded");

   property p_parity;
      (wr_en && paddr == `SCFRZ_OFF_PARITY) |=> ##1 parity_inj == $past(pwdata[7:0], 2);
   endproperty
   a_parity: assert property (p_parity) else $error("parity injection not applied");

   cv_thaw: cover property (hw_state_reg == S_THAWING ##1 hw_state_reg == S_THAWED);
   cv_freeze: cover property (hw_state_reg == S_FREEZING ##1 hw_state_reg == S_FROZEN);
   cv_ignored: cover property (hw_req && !hw_start);
   cv_unmapped: cover property (pslverr);

endmodule

//--- verilog/scfrz_consts.svh
// register offsets, field positions, reset values and timing counts of the freeze/system control block
`ifndef SCFRZ_CONSTS_SVH
`define SCFRZ_CONSTS_SVH
`define SCFRZ_ADDR_W 12
`define SCFRZ_OFF_CHAN_BASE 12'h000
`define SCFRZ_OFF_SRC 12'h010
`define SCFRZ_OFF_HWCTRL 12'h014
`define SCFRZ_OFF_INTF_GBL 12'h018
`define SCFRZ_OFF_INTF_INDIV 12'h01C
`define SCFRZ_OFF_ECC_BASE 12'h020
`define SCFRZ_OFF_PARITY 12'h050
`define SCFRZ_OFF_PINMUX 12'h054
`define SCFRZ_OFF_STRAP 12'h058
`define SCFRZ_OFF_MSG_BASE 12'h080
`define SCFRZ_HW_REQ_BIT 0
`define SCFRZ_HW_STATE_LSB 1
`define SCFRZ_RST_CHAN 9'h000
`define SCFRZ_RST_SRC 1'h0
`define SCFRZ_RST_INTF_GBL 1'h0
`define SCFRZ_RST_INTF_INDIV 7'h00
`define SCFRZ_RST_ECC 3'h0
`define SCFRZ_RST_PARITY 8'h00
`define SCFRZ_RST_PINMUX 32'h0000_0000
`define SCFRZ_RST_MSG 32'h0000_0000
`define SCFRZ_CODE_FROZEN 2'h0
`define SCFRZ_CODE_THAWING 2'h1
`define SCFRZ_CODE_THAWED 2'h2
`define SCFRZ_CODE_FREEZING 2'h3
`define SCFRZ_CLK_NS 40
`define SCFRZ_STEP_NS 200
`define SCFRZ_STEP_CYC ((`SCFRZ_STEP_NS + `SCFRZ_CLK_NS - 1) / `SCFRZ_CLK_NS)
`define SCFRZ_GATE_W 9
`endif

//--- verilog/scfrz_pkg.sv
// types shared by the freeze/system control block
package scfrz_pkg;
   // one freeze channel: every field high means the pin configuration is in control
   typedef struct packed {
      logic octcal_run;
      logic ioe_rel;
      logic oct_rel;
      logic dll_rel;
      logic slew_cfg;
      logic wkpull_cfg;
      logic tristate_cfg;
      logic bushold_cfg;
      logic cfg_en;
   } scfrz_gate_type;
   // per-memory ecc control
   typedef struct packed {
      logic inj_dbl;
      logic inj_sgl;
      logic en;
   } scfrz_ecc_type;
   typedef enum logic [1:0] {S_FROZEN, S_THAWING, S_THAWED, S_FREEZING} scfrz_hw_state_type;
endpackage

//--- sim/tb_soc_system_control_freeze.sv
// self-checking testbench of the freeze and system control block
`timescale 1ns/10ps
`include "scfrz_consts.svh"

module tb_soc_system_control_freeze
   import scfrz_pkg::*;
;
   logic pclk, presetn, cold_presetn, psel, penable, pwrite, pready, pslverr;
   logic [`SCFRZ_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, pin_sel;
   scfrz_gate_type [3:0] frz_gate;
   logic [6:0] fabric_intf_dis;
   scfrz_ecc_type [10:0] ecc_ctrl;
   logic [10:1] ecc_sgl_err, ecc_dbl_err, ecc_sgl_irq, ecc_dbl_irq, s_v, d_v;
   logic [7:0] parity_inj, par_v;
   logic [2:0] boot_strap, strap_v;
   logic [2:0] ecc_q [11];
   logic [8:0] gate_q [4];
   logic [31:0] msg_q [8];
   logic [31:0] pm_v;
   logic [6:0] ind_v;
   logic g_v;
   int error_cnt, checked;

   scfrz_top dut_u (.pclk(pclk), .presetn(presetn), .cold_presetn(cold_presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frz_gate(frz_gate), .fabric_intf_dis(fabric_intf_dis), .ecc_ctrl(ecc_ctrl), .ecc_sgl_err(ecc_sgl_err),
      .ecc_dbl_err(ecc_dbl_err), .ecc_sgl_irq(ecc_sgl_irq), .ecc_dbl_irq(ecc_dbl_irq), .parity_inj(parity_inj),
      .pin_sel(pin_sel), .boot_strap(boot_strap));

   // ******************************
   // clock, helpers and bus tasks
   // ******************************
   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   function automatic logic [6:0] exp_intf(input logic g, input logic [6:0] ind);
      return g ? 7'h7F : ind;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one apb transfer; waits for pready without assuming a latency
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 40);
      if (n >= 40) chk(32'h0, 32'h1, "pready never came");
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'h1, a, d, rd, err);
      chk({31'h0, err}, {31'h0, exp_err}, "write response");
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic exp_err, input string what);
      logic [31:0] rd;
      logic err;
      apb(1'h0, a, 32'h0, rd, err);
      chk(rd, exp, what);
      chk({31'h0, err}, {31'h0, exp_err}, "read response");
   endtask

   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(40 * 5000);
      error_cnt++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      wrap_up;
   end

   // ******************************
   // main sequence
   // ******************************
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = '0;
      pwdata = 32'h0;
      presetn = 1'h0;
      cold_presetn = 1'h0;
      ecc_sgl_err = '0;
      ecc_dbl_err = '0;
      error_cnt = 0;
      checked = 0;
      void'($urandom(53934));
      strap_v = 3'($urandom);
      boot_strap = strap_v;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      cold_presetn <= 1'h1;
      rdc(`SCFRZ_OFF_CHAN_BASE + 12'h4, 32'h0, 1'h0, "gate after reset");
      rdc(`SCFRZ_OFF_HWCTRL, {29'h0, `SCFRZ_CODE_FROZEN, 1'h0}, 1'h0, "hw state after reset");
      rdc(`SCFRZ_OFF_STRAP, {29'h0, strap_v}, 1'h0, "strap capture");
      // freeze channels: second pass rewrites channel 2 alone
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 4; c++) begin
            if (p == 0 || c == 2) begin
               gate_q[c] = (p == 0 && c == 0) ? 9'h1FF : (p == 0 && c == 3) ? 9'h000 : 9'($urandom);
               wr(`SCFRZ_OFF_CHAN_BASE + 12'(4 * c), {23'h0, gate_q[c]}, 1'h0);
            end
         end
         settle;
         for (int c = 0; c < 4; c++) begin
            chk(frz_gate[c], gate_q[c], "gate output");
            rdc(`SCFRZ_OFF_CHAN_BASE + 12'(4 * c), {23'h0, gate_q[c]}, 1'h0, "gate readback");
         end
      end
      // interface disables: each bit alone, a random mix, then the global bit
      for (int k = 0; k < 9; k++) begin
         ind_v = (k < 7) ? 7'(1 << k) : (k == 7) ? 7'($urandom) : 7'h00;
         g_v = (k == 8);
         wr(`SCFRZ_OFF_INTF_INDIV, {25'h0, ind_v}, 1'h0);
         wr(`SCFRZ_OFF_INTF_GBL, {31'h0, g_v}, 1'h0);
         settle;
         chk(fabric_intf_dis, exp_intf(g_v, ind_v), "interface disables");
      end
      // ecc enables and every injection code
      for (int i = 0; i < 11; i++) begin
         ecc_q[i] = (i < 8) ? 3'(i) : 3'($urandom);
         wr(`SCFRZ_OFF_ECC_BASE + 12'(4 * i), {29'h0, ecc_q[i]}, 1'h0);
      end
      settle;
      for (int i = 0; i < 11; i++) begin
         chk(ecc_ctrl[i], ecc_q[i], "ecc control");
         rdc(`SCFRZ_OFF_ECC_BASE + 12'(4 * i), {29'h0, ecc_q[i]}, 1'h0, "ecc readback");
      end
      for (int k = 0; k < 4; k++) begin
         s_v = (k == 0) ? 10'h3FF : 10'($urandom);
         d_v = (k == 1) ? 10'h3FF : 10'($urandom);
         @(posedge pclk);
         ecc_sgl_err <= s_v;
         ecc_dbl_err <= d_v;
         @(posedge pclk);
         #1;
         chk(ecc_sgl_irq, s_v, "single error irq");
         chk(ecc_dbl_irq, d_v, "double error irq");
      end
      par_v = 8'($urandom);
      pm_v = $urandom;
      wr(`SCFRZ_OFF_PARITY, {24'h0, par_v}, 1'h0);
      wr(`SCFRZ_OFF_PINMUX, pm_v, 1'h0);
      settle;
      chk(parity_inj, par_v, "parity injection");
      chk(pin_sel, pm_v, "pin select");
      for (int i = 0; i < 8; i++) begin
         msg_q[i] = $urandom;
         wr(`SCFRZ_OFF_MSG_BASE + 12'(4 * i), msg_q[i], 1'h0);
      end
      for (int i = 0; i < 8; i++) rdc(`SCFRZ_OFF_MSG_BASE + 12'(4 * i), msg_q[i], 1'h0, "message");
      wr(12'h060, $urandom, 1'h1);
      rdc(12'h060, 32'h0, 1'h1, "unmapped read");
      rdc(12'h002, 32'h0, 1'h1, "unaligned read");
      // hardware sequencer: thaw, ignored request, then freeze
      wr(`SCFRZ_OFF_SRC, 32'h1, 1'h0);
      wr(`SCFRZ_OFF_HWCTRL, 32'h1, 1'h0);
      settle;
      rdc(`SCFRZ_OFF_HWCTRL, {29'h0, `SCFRZ_CODE_THAWING, 1'h0}, 1'h0, "thaw in progress");
      wr(`SCFRZ_OFF_HWCTRL, 32'h1, 1'h0);
      repeat (50) @(posedge pclk);
      rdc(`SCFRZ_OFF_HWCTRL, {29'h0, `SCFRZ_CODE_THAWED, 1'h0}, 1'h0, "thawed");
      chk(frz_gate[1], 9'h1FF, "hw thawed channel");
      chk(frz_gate[0], gate_q[0], "channel 0 untouched");
      wr(`SCFRZ_OFF_HWCTRL, 32'h1, 1'h0);
      repeat (50) @(posedge pclk);
      rdc(`SCFRZ_OFF_HWCTRL, {29'h0, `SCFRZ_CODE_FROZEN, 1'h0}, 1'h0, "frozen");
      chk(frz_gate[1], 9'h000, "hw frozen channel");
      wr(`SCFRZ_OFF_SRC, 32'h0, 1'h0);
      settle;
      chk(frz_gate[1], gate_q[1], "software source");
      // warm reset keeps cold-only groups
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      settle;
      chk(parity_inj, 8'h00, "parity after warm reset");
      chk(pin_sel, pm_v, "pin select after warm reset");
      chk(frz_gate[2], gate_q[2], "gate after warm reset");
      chk(ecc_ctrl[9], ecc_q[9], "ecc after warm reset");
      chk(fabric_intf_dis, 7'h7F, "disables after warm reset");
      for (int i = 0; i < 8; i++) rdc(`SCFRZ_OFF_MSG_BASE + 12'(4 * i), msg_q[i], 1'h0, "message warm");
      // cold reset clears everything and recaptures straps
      @(posedge pclk);
      presetn <= 1'h0;
      cold_presetn <= 1'h0;
      strap_v = ~strap_v;
      boot_strap <= strap_v;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      cold_presetn <= 1'h1;
      settle;
      chk(pin_sel, 32'h0, "pin select after cold reset");
      chk(frz_gate[0], 9'h000, "gate after cold reset");
      for (int i = 0; i < 8; i++) rdc(`SCFRZ_OFF_MSG_BASE + 12'(4 * i), 32'h0, 1'h0, "message cold");
      rdc(`SCFRZ_OFF_STRAP, {29'h0, strap_v}, 1'h0, "strap recapture");
      wrap_up;
   end
endmodule
